// >>> rtl/scm_host.sv
// Master FPGA end: makes the configuration clock and collects the serial stream
`timescale 1ns/100ps
module scm_host
  import scm_pkg::*;
#(
  parameter int unsigned FPGA_CONFIG_CLOCK_OUT_DIV = SCM_FPGA_CONFIG_CLOCK_OUT_DIV
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  scm_link_if.host        link,
  input  wire logic       start,
  input  wire logic       finish,
  input  wire logic       keep_counters,
  input  wire logic       paging,
  input  wire logic [1:0] page,
  input  wire logic       isp_request,
  output logic            bit_valid,
  output logic            bit_value,
  output logic            mem_ready
);

  initial begin
    if (FPGA_CONFIG_CLOCK_OUT_DIV < 2 || FPGA_CONFIG_CLOCK_OUT_DIV > 65536) $error("FPGA_CONFIG_CLOCK_OUT_DIV out of range");
  end

  scm_host_state_type state_q, state_d;
  logic [15:0] div_q, div_d;
  logic        fpga_config_clock_out_q, fpga_config_clock_out_d;
  logic        bv_q, bv_d;
  logic        bd_q, bd_d;

  always_comb begin
    state_d = state_q;
    div_d   = div_q;
    fpga_config_clock_out_d  = fpga_config_clock_out_q;
    bv_d    = 1'b0;
    bd_d    = bd_q;
    case (state_q)
      SCM_HS_RESET: begin
        fpga_config_clock_out_d = 1'b0;
        if (start && link.ready_line) state_d = SCM_HS_RUN;
      end
      SCM_HS_RUN: begin
        if (finish) begin
          state_d = SCM_HS_END;
          fpga_config_clock_out_d  = 1'b0;
        end else if (div_q == 16'(FPGA_CONFIG_CLOCK_OUT_DIV - 1)) begin
          div_d  = 16'h0000;
          fpga_config_clock_out_d = ~fpga_config_clock_out_q;
          if (!fpga_config_clock_out_q) begin
            bv_d = 1'b1; // RULE12
            bd_d = link.data_line;
          end
        end else begin
          div_d = div_q + 16'h0001;
        end
      end
      SCM_HS_END: begin
        if (start) state_d = SCM_HS_RESET;
      end
      default: state_d = SCM_HS_RESET;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= SCM_HS_RESET;
      div_q   <= 16'h0000;
      fpga_config_clock_out_q  <= 1'b0;
      bv_q    <= 1'b0;
      bd_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      div_q   <= div_d;
      fpga_config_clock_out_q  <= fpga_config_clock_out_d;
      bv_q    <= bv_d;
      bd_q    <= bd_d;
    end
  end

  assign link.fpga_config_clock_out = fpga_config_clock_out_q; // RULE12
  // Clear held low in reset, and after the end unless counters are kept
  assign link.clear_oe = (state_q == SCM_HS_RUN) ||
                         (state_q == SCM_HS_END && keep_counters); // RULE17 RULE18
  assign link.chip_enable_n         = (state_q != SCM_HS_RUN);
  assign link.isp_mode_select_n     = ~isp_request; // RULE3
  assign link.page_enable           = paging; // RULE14
  assign link.page_select           = paging ? page : 2'b00; // RULE14
  assign link.program_device_select = isp_request;
  assign bit_valid = bv_q;
  assign bit_value = bd_q;
  assign mem_ready = link.ready_line;

endmodule : scm_host

// >>> rtl/scm_link_if.sv
// Interface joining the configuration memory and the master FPGA end
`timescale 1ns/100ps
interface scm_link_if;
  logic       fpga_config_clock_out;
  logic       clear_oe;
  logic       chip_enable_n;
  logic       isp_mode_select_n;
  logic       page_enable;
  logic [1:0] page_select;
  logic       program_device_select;
  logic       data_out;
  logic       data_oe;
  logic       cascade_enable_out_n;
  logic       ready_oe;
  logic       data_line;
  logic       ready_line;

  // Wire levels worked out from the drive enables; pull-up when floating
  assign data_line  = data_oe ? data_out : 1'b1;
  assign ready_line = ready_oe ? 1'b0 : 1'b1;

  modport mem (
    input  fpga_config_clock_out,
    input  clear_oe,
    input  chip_enable_n,
    input  isp_mode_select_n,
    input  page_enable,
    input  page_select,
    input  program_device_select,
    output data_out,
    output data_oe,
    output cascade_enable_out_n,
    output ready_oe
  );

  modport host (
    output fpga_config_clock_out,
    output clear_oe,
    output chip_enable_n,
    output isp_mode_select_n,
    output page_enable,
    output page_select,
    output program_device_select,
    input  data_line,
    input  ready_line
  );
endinterface : scm_link_if

// >>> rtl/scm_memory.sv
// Configuration memory end: address counter, paging, cascade and data driver
`timescale 1ns/100ps

// Operation
// RULE1: Low mode select: device select chips programming
// RULE2: Ready pulled low during power-up reset
// RULE3: Host keeps mode select high while reading
// RULE4: Paging picks one of four equal quarters
// RULE5: No paging: ignore page bits, whole array
// RULE6: Clear low: counter cleared, data floated
// RULE7: Chip enable high: counter frozen, data floated
// RULE8: Enable high and selected: counter, driver on
// RULE9: New clear low floats regardless of enable
// RULE10: After last bit, float data for next
// RULE11: Power-up clears counter automatically
// RULE12: Master clock drives memory, data to master
// RULE13: Cascade output wired to next chip enable
// RULE14: Board ties page inputs when unused
// RULE15: Edge after last bit: cascade low, float
// RULE16: Next memory sees low enable, drives data
// RULE17: Controller pulls clear low after configuration
// RULE18: Clear may be tied high permanently
// RULE19: Count only when selected and enabled
// RULE20: Cascade output low at selected top address
// RULE21: Cascade holds, follows enable, then stays high
// RULE22: Clock steps address and bit counters
// RULE23: Each rising clock presents next stored bit
module scm_memory
  import scm_pkg::*;
#(
  parameter bit          BIG_PART   = 1'b0,
  parameter int unsigned PAGE_SHIFT = BIG_PART ? SCM_PAGE_SH_8MB : SCM_PAGE_SH_4MB,
  parameter int unsigned POR_CYCLES = SCM_POR_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  scm_link_if.mem   link,
  input  wire logic prog_ack,
  output logic      prog_select,
  output logic      stream_active,
  output logic [19:0] current_addr
);

  // ****************************************************************
  // Geometry
  // ****************************************************************
  // Four equal pages; the defaults give the documented part sizes
  localparam logic [19:0] PAGE_TOP = 20'((64'd1 << PAGE_SHIFT) - 64'd1);
  localparam logic [19:0] DEV_TOP  = 20'((64'(SCM_PAGE_COUNT) << PAGE_SHIFT) - 64'd1);

  initial begin
    if (POR_CYCLES < 1 || POR_CYCLES > 65536) begin
      $error("POR_CYCLES out of range");
    end
    if (PAGE_SHIFT < 1 || PAGE_SHIFT > 18) begin
      $error("PAGE_SHIFT out of range");
    end
    if (PAGE_SHIFT == (BIG_PART ? SCM_PAGE_SH_8MB : SCM_PAGE_SH_4MB) &&
        (DEV_TOP != (BIG_PART ? SCM_TOP_8MB : SCM_TOP_4MB) ||
         PAGE_TOP != (BIG_PART ? SCM_PAGE_TOP_8MB : SCM_PAGE_TOP_4MB))) begin
      $error("Default geometry differs from the part");
    end
  end

  // Stored bits: a fixed pattern stands in for the flash array
  function automatic logic array_bit(input logic [19:0] a);
    array_bit = ^a;
  endfunction : array_bit

  // ****************************************************************
  // State
  // ****************************************************************
  scm_state_type state_q, state_d;
  logic [19:0]   addr_q, addr_d;
  logic [15:0]   por_q, por_d;
  logic          ceo_n_q, ceo_n_d;
  logic          data_q, data_d;
  logic          dlast_q, dlast_d;
  logic          clk_q, clk_d;
  logic          clk_rise;
  logic [19:0]   base_addr;
  logic [19:0]   top_addr;
  logic          read_mode;
  logic          run;

  assign clk_rise  = link.fpga_config_clock_out & ~clk_q; // RULE22
  assign read_mode = link.isp_mode_select_n;
  assign run       = read_mode & link.clear_oe & ~link.chip_enable_n; // RULE19 RULE8

  // ****************************************************************
  // Link clock sampling
  // ****************************************************************
  always_comb begin
    clk_d = link.fpga_config_clock_out;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= clk_d;
    end
  end

  // ****************************************************************
  // Power-up timer
  // ****************************************************************
  always_comb begin
    por_d = por_q;
    if (state_q == SCM_ST_POR && por_q != 16'(POR_CYCLES - 1)) begin
      por_d = por_q + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      por_q <= 16'h0000;
    end else begin
      por_q <= por_d;
    end
  end

  // ****************************************************************
  // Page decode
  // ****************************************************************

  always_comb begin
    if (link.page_enable) begin
      base_addr = 20'(link.page_select) << PAGE_SHIFT; // RULE4
      top_addr  = base_addr | PAGE_TOP; // RULE4 RULE20
    end else begin
      base_addr = 20'h0_0000; // RULE5
      top_addr  = DEV_TOP; // RULE5 RULE20
    end
  end

  // ****************************************************************
  // Read control
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    addr_d  = addr_q;
    ceo_n_d = ceo_n_q;
    data_d  = data_q;
    dlast_d = dlast_q;
    case (state_q)
      SCM_ST_POR: begin
        addr_d  = 20'h0_0000; // RULE11
        ceo_n_d = 1'b1;
        if (por_q == 16'(POR_CYCLES - 1)) begin
          state_d = SCM_ST_IDLE;
        end
      end
      SCM_ST_IDLE, SCM_ST_STREAM, SCM_ST_DONE: begin
        // Clear low outranks chip enable and the clock
        if (read_mode && !link.clear_oe) begin
          addr_d  = base_addr; // RULE6 RULE9
          ceo_n_d = 1'b1; // RULE21
          dlast_d = 1'b0;
          data_d  = array_bit(base_addr);
          state_d = SCM_ST_IDLE;
        end else if (state_q == SCM_ST_DONE) begin
          ceo_n_d = link.chip_enable_n; // RULE21
        end else if (run && clk_rise) begin
          state_d = SCM_ST_STREAM;
          // Counter parks on the top address
          if (addr_q == top_addr) begin
            ceo_n_d = 1'b0; // RULE15 RULE20
            dlast_d = 1'b1; // RULE10
            state_d = SCM_ST_DONE;
          end else begin
            addr_d = addr_q + 20'h0_0001; // RULE23 RULE22
            data_d = array_bit(addr_q + 20'h0_0001); // RULE23
          end
        end else if (state_q == SCM_ST_IDLE) begin
          data_d = array_bit(addr_q);
        end
      end
      default: state_d = SCM_ST_POR;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= SCM_ST_POR;
      addr_q  <= 20'h0_0000;
      ceo_n_q <= 1'b1;
      data_q  <= 1'b0;
      dlast_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q  <= addr_d;
      ceo_n_q <= ceo_n_d;
      data_q  <= data_d;
      dlast_q <= dlast_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.ready_oe = (state_q == SCM_ST_POR); // RULE2
  assign link.data_out = data_q;
  // Data floats at the end so the next memory can drive
  assign link.data_oe  = run && !dlast_q && state_q != SCM_ST_POR; // RULE6 RULE7 RULE10 RULE16
  assign link.cascade_enable_out_n = read_mode ? ceo_n_q : 1'b1;
  assign prog_select   = ~read_mode & link.program_device_select & prog_ack; // RULE1
  assign stream_active = link.data_oe;
  assign current_addr  = addr_q;

endmodule : scm_memory

// >>> rtl/scm_pkg.sv
// Package with constants and types for the serial configuration memory read-out
package scm_pkg;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int unsigned SCM_ADDR_W_4MB   = 19;
  localparam int unsigned SCM_ADDR_W_8MB   = 20;
  localparam int unsigned SCM_PAGE_COUNT   = 4;
  localparam int unsigned SCM_PAGE_SEL_W   = 2;
  localparam int unsigned SCM_PAGE_SH_4MB  = 16;
  localparam int unsigned SCM_PAGE_SH_8MB  = 17;
  localparam logic [19:0] SCM_TOP_4MB      = 20'h3_FFFF;
  localparam logic [19:0] SCM_TOP_8MB      = 20'h7_FFFF;
  localparam logic [19:0] SCM_PAGE_TOP_4MB = 20'h0_FFFF;
  localparam logic [19:0] SCM_PAGE_TOP_8MB = 20'h1_FFFF;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned SCM_CLK_HZ          = 10_000_000;
  localparam int unsigned SCM_POR_CYCLES      = 16;
  localparam int unsigned SCM_FPGA_CONFIG_CLOCK_OUT_DIV        = 2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    SCM_ST_POR    = 2'b00,
    SCM_ST_IDLE   = 2'b01,
    SCM_ST_STREAM = 2'b10,
    SCM_ST_DONE   = 2'b11
  } scm_state_type;

  typedef enum logic [1:0] {
    SCM_HS_RESET = 2'b00,
    SCM_HS_RUN   = 2'b01,
    SCM_HS_END   = 2'b10
  } scm_host_state_type;

endpackage : scm_pkg

// >>> test/scm_link_sva.sv
// Checker watching the link between the memory and the FPGA end
`timescale 1ns/100ps
module scm_link_sva
  import scm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic fpga_config_clock_out,
  input wire logic clear_oe,
  input wire logic chip_enable_n,
  input wire logic isp_mode_select_n,
  input wire logic data_out,
  input wire logic data_oe,
  input wire logic cascade_enable_out_n,
  input wire logic ready_oe
);
  // ****************************************************************
  // Link properties
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_ready_por_low: assert property ($rose(resetn) |-> ready_oe [*8])
    else $error("ready released early");
  a_por_no_drive: assert property (ready_oe |-> !data_oe && cascade_enable_out_n)
    else $error("driving during power-up");
  a_clear_floats: assert property (!clear_oe ##1 !clear_oe |-> !data_oe)
    else $error("data driven while clear low");
  a_ce_high_floats: assert property (chip_enable_n ##1 chip_enable_n |-> !data_oe)
    else $error("data driven while deselected");
  a_ce_high_frozen: assert property ((chip_enable_n && clear_oe) [*2] |-> $stable(data_out))
    else $error("data stepped while deselected");
  a_enabled_drives: assert property ((clear_oe && !chip_enable_n && isp_mode_select_n
    && cascade_enable_out_n && !ready_oe) [*2] |-> data_oe)
    else $error("driver off while enabled");
  a_data_on_rise: assert property (data_oe && $past(data_oe) && $changed(data_out)
    |-> $past(fpga_config_clock_out) && !$past(fpga_config_clock_out, 2))
    else $error("data stepped without clock rise");
  a_ceo_floats: assert property ($fell(cascade_enable_out_n) |-> !data_oe)
    else $error("data driven after cascade out");
  a_ceo_holds: assert property (!cascade_enable_out_n && !chip_enable_n && clear_oe
    && isp_mode_select_n |=> !cascade_enable_out_n)
    else $error("cascade out released early");
  a_ceo_cleared: assert property (!clear_oe ##1 !clear_oe |-> cascade_enable_out_n)
    else $error("cascade out low after clear");
endmodule : scm_link_sva

// >>> test/serial_config_memory_readout_tb_top.sv
// Testbench joining the memory and FPGA ends over the link
`timescale 1ns/100ps
module serial_config_memory_readout_tb_top;
  import scm_pkg::*;
  logic        sys_clk, resetn, start, finish, keep_counters, paging, isp_request, prog_ack;
  logic [1:0]  page;
  logic        bit_valid, bit_value, mem_ready, prog_select, stream_active;
  logic [19:0] current_addr;
  int          err_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  // Small pages so that a page top is reached in a short run
  localparam int unsigned SIM_PAGE_SH = 4;

  scm_link_if link ();
  scm_link_if link_b ();
  scm_memory #(
    .BIG_PART(1'b0), .PAGE_SHIFT(SIM_PAGE_SH), .POR_CYCLES(SCM_POR_CYCLES)
  ) i_scm_memory (
    .sys_clk(sys_clk), .resetn(resetn), .link(link), .prog_ack(prog_ack),
    .prog_select(prog_select), .stream_active(stream_active), .current_addr(current_addr));
  // Second memory of the chain, fed from the first one's cascade output
  assign link_b.fpga_config_clock_out = link.fpga_config_clock_out;
  assign link_b.clear_oe              = link.clear_oe;
  assign link_b.chip_enable_n         = link.cascade_enable_out_n;
  assign link_b.isp_mode_select_n     = link.isp_mode_select_n;
  assign link_b.page_enable           = link.page_enable;
  assign link_b.page_select           = link.page_select;
  assign link_b.program_device_select = link.program_device_select;
  scm_memory #(.BIG_PART(1'b0), .PAGE_SHIFT(SIM_PAGE_SH)) i_scm_memory_b (
    .sys_clk(sys_clk), .resetn(resetn), .link(link_b), .prog_ack(prog_ack),
    .prog_select(), .stream_active(), .current_addr());
  scm_host #(.FPGA_CONFIG_CLOCK_OUT_DIV(SCM_FPGA_CONFIG_CLOCK_OUT_DIV)) i_scm_host (
    .sys_clk(sys_clk), .resetn(resetn), .link(link), .start(start), .finish(finish),
    .keep_counters(keep_counters), .paging(paging), .page(page), .isp_request(isp_request),
    .bit_valid(bit_valid), .bit_value(bit_value), .mem_ready(mem_ready));
  scm_link_sva i_scm_link_sva (
    .sys_clk(sys_clk), .resetn(resetn), .fpga_config_clock_out(link.fpga_config_clock_out),
    .clear_oe(link.clear_oe), .chip_enable_n(link.chip_enable_n),
    .isp_mode_select_n(link.isp_mode_select_n), .data_out(link.data_out),
    .data_oe(link.data_oe), .cascade_enable_out_n(link.cascade_enable_out_n),
    .ready_oe(link.ready_oe));

  // ****************************************************************
  // Checking and reporting
  // ****************************************************************
  task automatic check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_addr(input string what, input logic [19:0] exp, input logic [19:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check_addr

  task automatic summarize();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic por_check();
    @(negedge sys_clk);
    check_bit("ready in power-up", 1'b0, mem_ready);
    check_addr("power-up addr", 20'h0_0000, current_addr);
    repeat (SCM_POR_CYCLES + 2) @(negedge sys_clk);
    check_bit("ready after power-up", 1'b1, mem_ready);
  endtask : por_check

  task automatic isp_check();
    @(posedge sys_clk);
    isp_request <= 1'b1;
    prog_ack    <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check_bit("device select", 1'b1, prog_select);
    check_bit("isp floats data", 1'b0, stream_active);
    @(posedge sys_clk);
    prog_ack <= 1'b0;
    repeat (2) @(negedge sys_clk);
    check_bit("select without grant", 1'b0, prog_select);
    @(posedge sys_clk);
    isp_request <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : isp_check

  task automatic read_stream(input logic pg_en, input logic [1:0] pg, input logic [19:0] base,
                             input logic keep);
    int got;
    int guard;
    got   = 0;
    guard = 0;
    @(posedge sys_clk);
    paging <= pg_en;
    page   <= pg;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check_addr("page base", base, current_addr);
    @(posedge sys_clk);
    start <= 1'b1;
    repeat (2) @(posedge sys_clk);
    start <= 1'b0;
    while (got < 12 && guard < 400) begin
      @(negedge sys_clk);
      guard++;
      if (bit_valid === 1'b1) begin
        check_bit("stream bit", ^(base + 20'(got)), bit_value);
        check_bit("driving", 1'b1, stream_active);
        got++;
      end
    end
    check_bit("bit count", 1'b1, got == 12);
    @(posedge sys_clk);
    keep_counters <= keep;
    finish        <= 1'b1;
    @(posedge sys_clk);
    finish <= 1'b0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    if (keep) begin
      check_bit("clear held", 1'b1, link.clear_oe);
    end else begin
      check_bit("line floated", 1'b1, link.data_line);
      check_addr("counter cleared", base, current_addr);
    end
  endtask : read_stream

  task automatic cascade_check();
    int got;
    int guard;
    got   = 0;
    guard = 0;
    @(posedge sys_clk);
    paging        <= 1'b1;
    page          <= 2'b00;
    keep_counters <= 1'b1;
    repeat (4) @(posedge sys_clk);
    start <= 1'b1;
    repeat (2) @(posedge sys_clk);
    start <= 1'b0;
    while (got < 16 && guard < 400) begin
      @(negedge sys_clk);
      guard++;
      if (bit_valid === 1'b1) begin
        check_bit("page end bit", ^(20'(got)), bit_value);
        got++;
      end
    end
    check_bit("page bit count", 1'b1, got == 16);
    repeat (3) @(negedge sys_clk);
    check_bit("cascade out at top", 1'b0, link.cascade_enable_out_n);
    check_bit("first floats", 1'b0, link.data_oe);
    check_bit("next drives", 1'b1, link_b.data_oe);
    check_addr("top held", (20'h0_0001 << SIM_PAGE_SH) - 20'h0_0001, current_addr);
    @(posedge sys_clk);
    finish <= 1'b1;
    @(posedge sys_clk);
    finish <= 1'b0;
    repeat (2) @(negedge sys_clk);
    check_bit("cascade follows enable", 1'b1, link.cascade_enable_out_n);
    check_bit("next floats", 1'b0, link_b.data_oe);
  endtask : cascade_check

  initial begin
    resetn        = 1'b0;
    start         = 1'b0;
    finish        = 1'b0;
    keep_counters = 1'b0;
    paging        = 1'b0;
    page          = 2'b00;
    isp_request   = 1'b0;
    prog_ack      = 1'b0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    por_check();
    isp_check();
    for (int p = 0; p < 4; p++) begin
      read_stream(1'b1, 2'(p), 20'(p) << SIM_PAGE_SH, 1'b0);
    end
    read_stream(1'b0, 2'b10, 20'h0_0000, 1'b0);
    read_stream(1'b0, 2'b01, 20'h0_0000, 1'b1);
    cascade_check();
    summarize();
  end
endmodule : serial_config_memory_readout_tb_top
